// File: rtl/led_seq_pkg.sv
/*
 Shared constants and types for the backlight pulse-dimming sequencer.
 Assumes a single 250 MHz core clock; all times convert to its cycles.
*/
package led_seq_pkg;
	// Clock and documented times
	localparam int CLK_PERIOD_NS  = 4;
	localparam int PULSE_MIN_NS   = 500;
	localparam int PULSE_MAX_NS   = 500_000;
	localparam int OFF_TIMEOUT_NS = 4_000_000;
	localparam int RAMP_STEP_NS   = 1_000;
	localparam int CP_FREQ_KHZ    = 1_000;

	// Least times round up, longest round down
	localparam int PULSE_MIN_CYC   =
		(PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MAX_CYC   = PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int OFF_TIMEOUT_CYC =
		(OFF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_STEP_CYC   = RAMP_STEP_NS / CLK_PERIOD_NS;
	localparam int CP_HALF_CYC     =
		1_000_000 / (2 * CP_FREQ_KHZ * CLK_PERIOD_NS);

	// Counter width and current levels (1..32 of full scale)
	localparam int         CNT_W      = 20;
	localparam logic [5:0] LEVEL_FULL = 6'h20;
	localparam logic [5:0] LEVEL_MIN  = 6'h01;

	// Thermal figures in degrees C and reference in mV
	localparam logic [7:0] TSD_TRIP_C      = 8'hA0;
	localparam logic [7:0] TSD_HYST_C      = 8'h14;
	localparam logic [7:0] DERATE_KNEE_C   = 8'h28;
	localparam logic [9:0] REF_NOM_MV      = 10'h258;
	localparam logic [11:0] DERATE_MV_PER_C = 12'h00A;

	// Cathode thresholds in mV
	localparam logic [7:0] CATHODE_LOW_MV = 8'h58;
	localparam logic [7:0] CATHODE_REG_MV = 8'h7A;

	typedef enum logic [3:0] {
		CP_OFF        = 4'h1,
		CP_PRECHARGE  = 4'h2,
		CP_ONE_X      = 4'h4,
		CP_ONE_HALF_X = 4'h8
	} cp_mode_t;

	typedef enum logic [2:0] {
		CH_OFF  = 3'h1,
		CH_RAMP = 3'h2,
		CH_ON   = 3'h4
	} chan_state_t;

	typedef struct packed {
		logic out_near_in;
		logic out_short;
		logic reg_dropout;
		logic min_cathode_voltage_low;
		logic headroom_ok;
		logic out_above_5v;
	} sense_t;

	typedef struct packed {
		logic       active;
		logic       ramping;
		logic [5:0] level;
		logic [5:0] drive;
	} chan_stat_t;
endpackage

// File: rtl/dim_channel.sv
/*
 One serial-pulse dimming channel: low-pulse width measurement,
 32-step level with wrap, soft-start ramp and off timeout.
 Assumes enable_dim is already synchronised to core_clk.
*/
`timescale 1ns/10ps
module dim_channel
	import led_seq_pkg::*;
#(
	parameter logic [CNT_W-1:0] PULSE_MAX   = CNT_W'(PULSE_MAX_CYC),
	parameter logic [CNT_W-1:0] OFF_TIMEOUT = CNT_W'(OFF_TIMEOUT_CYC)
)(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Enable pin and ramp permission
	input  wire logic enable_dim,
	input  wire logic ramp_go,
	// Channel status
	output chan_stat_t stat
);
	chan_state_t      state_q;
	logic             en_prev_q;
	logic [CNT_W-1:0] low_cnt_q;
	logic [5:0]       level_q;
	logic [5:0]       drive_q;
	logic [7:0]       step_q;
	logic             rise;
	logic             timeout;
	logic             pulse_ok;

	assign rise = enable_dim & ~en_prev_q;
	assign timeout = (low_cnt_q >= OFF_TIMEOUT);
	// Lows between the pulse window and the timeout are ignored
	assign pulse_ok = rise && (state_q != CH_OFF)
		&& (low_cnt_q >= CNT_W'(PULSE_MIN_CYC))
		&& (low_cnt_q <= PULSE_MAX);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			en_prev_q <= 1'b0;
		else
			en_prev_q <= enable_dim;
	end

	// Saturates so a held-low pin cannot wrap the count
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			low_cnt_q <= '0;
		else if (enable_dim)
			low_cnt_q <= '0;
		else if (!timeout)
			low_cnt_q <= low_cnt_q + CNT_W'(1);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= CH_OFF;
			level_q <= LEVEL_FULL;
		end else begin
			case (state_q)
				CH_OFF: if (rise) begin
					state_q <= CH_RAMP;
					level_q <= LEVEL_FULL;
				end
				CH_RAMP, CH_ON: if (!enable_dim && timeout) begin
					state_q <= CH_OFF;
				end else if (pulse_ok) begin
					if (level_q == LEVEL_MIN) begin
						level_q <= LEVEL_FULL;
						state_q <= CH_RAMP;
					end else begin
						level_q <= level_q - 6'h01;
					end
				end else if (state_q == CH_RAMP && drive_q == level_q) begin
					state_q <= CH_ON;
				end
				default: state_q <= CH_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_q <= '0;
			step_q <= '0;
		end else if (state_q == CH_OFF
			|| (pulse_ok && level_q == LEVEL_MIN)) begin
			drive_q <= '0;
			step_q <= '0;
		end else if (drive_q > level_q) begin
			drive_q <= level_q;
		end else if (state_q == CH_RAMP && ramp_go) begin
			if (step_q == 8'(RAMP_STEP_CYC - 1)) begin
				step_q <= '0;
				if (drive_q < level_q)
					drive_q <= drive_q + 6'h01;
			end else begin
				step_q <= step_q + 8'h01;
			end
		end
	end

	assign stat = '{active: (state_q != CH_OFF),
		ramping: (state_q == CH_RAMP), level: level_q, drive: drive_q};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_wake;
		state_q == CH_OFF && rise;
	endsequence

	chk_pulse_step: assert property (
		pulse_ok && level_q != LEVEL_MIN
		|=> level_q == $past(level_q) - 6'h01)
		else $error("dim pulse did not lower level by one");
	chk_level_wrap: assert property (
		pulse_ok && level_q == LEVEL_MIN
		|=> level_q == LEVEL_FULL && drive_q == 6'h00
			&& state_q == CH_RAMP)
		else $error("minimum level did not wrap into a new ramp");
	chk_enable_ramp: assert property (
		s_wake |=> state_q == CH_RAMP && level_q == LEVEL_FULL
			&& drive_q == 6'h00)
		else $error("enable did not start a full-scale ramp");
	chk_chan_timeout: assert property (
		state_q != CH_OFF && !enable_dim && timeout
		|=> state_q == CH_OFF)
		else $error("held-low enable did not turn channel off");
	chk_ramp_step: assert property (
		state_q == CH_RAMP && drive_q <= level_q
		|=> drive_q <= $past(drive_q) + 6'h01)
		else $error("ramp rose by more than one step");
endmodule // dim_channel

// File: rtl/led_pulse_dim_sequencer.sv
/*
 Top of the five-LED backlight sequencer: pin synchronisers, main and
 sub dimming channels, duty-input path, charge-pump mode control,
 thermal shutdown and reference derating.
 Assumes the analog comparators and temperature sensor deliver
 asynchronous levels, and the pump and regulators obey these controls.
*/
`timescale 1ns/10ps
// Function
// - Enable rising soft-starts to target in 32 steps
// - Each valid pulse lowers level one step
// - Pulse at minimum level wraps to full
// - Wrap to full restarts the soft-start ramp
// - Both enables low 4ms shuts device down
// - Static enable gives full brightness
// - Main and sub groups dim independently
// - Precharge from input, then enter 1x
// - Dropout after ramp selects 1.5x mode
// - Shorted output holds the precharge stage
// - Low cathode in 1x selects 1.5x
// - Return to 1x only on headroom
// - Open LED gates pump near 5V
// - LED tied to output disables its regulator
// - Thermal shutdown at 160C, resume 20C cooler
// - Reference derates above 40C
// - Duty variant sets all currents together
// - Pump switches at 1MHz in 1.5x
// - Sub enable held low turns off sub only
// - Pulses during soft-start set final level
module led_pulse_dim_sequencer
	import led_seq_pkg::*;
#(
	parameter logic [CNT_W-1:0] PULSE_MAX   = CNT_W'(PULSE_MAX_CYC),
	parameter logic [CNT_W-1:0] OFF_TIMEOUT = CNT_W'(OFF_TIMEOUT_CYC),
	parameter int               FILT_SHIFT  = 20
)(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Host dimming pins, asynchronous
	input  wire logic        main_group_enable_dim,
	input  wire logic        sub_group_enable_dim,
	input  wire logic        pwm_dim_in,
	input  wire logic        duty_variant_sel,
	// Analog decisions, asynchronous
	input  wire sense_t      sense_in,
	input  wire logic [4:0]  led_open,
	input  wire logic [4:0]  led_tied_out,
	input  wire logic [7:0]  die_temp_c,
	// Pump and bias controls
	output cp_mode_t         cp_mode,
	output logic             cp_switch_clk,
	output logic             ramp_src_en,
	output logic             shutdown,
	output logic             out_pulldown_en,
	output logic [7:0]       cathode_target_mv,
	output logic [9:0]       ref_mv,
	// Current regulators
	output logic [4:0]       reg_enable,
	output logic [4:0][5:0]  led_current
);
	localparam int SYNC_W = 4 + $bits(sense_t) + 18;

	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic              main_en;
	logic              sub_en;
	logic              pwm_en;
	logic              variant;
	sense_t            sense;
	logic [4:0]        open_s;
	logic [4:0]        tied_s;
	logic [7:0]        temp_s;
	chan_stat_t        stat [3];
	logic [2:0]        chan_en;
	logic [1:0]        grp_active;
	logic [5:0]        grp_drive [2];
	cp_mode_t          cp_q;
	logic              thermal_sd_q;
	logic              ramp_prev_q;
	logic [6:0]        half_q;
	logic              cp_clk_q;
	logic [FILT_SHIFT+5:0] acc_q;
	logic [5:0]        duty_level;
	logic [11:0]       derate_mv;
	logic              any_active;
	logic              run;
	logic              pump_ready;
	logic              ramp_any;
	logic              ramp_end;
	logic              ovp_gate;

	function automatic logic group_of(input int led);
		return (led >= 3);
	endfunction

	// Temperature bits may skew by a cycle; the sensor moves slowly
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {main_group_enable_dim, sub_group_enable_dim,
				pwm_dim_in, duty_variant_sel, sense_in, led_open,
				led_tied_out, die_temp_c};
			sync_q <= meta_q;
		end
	end
	assign {main_en, sub_en, pwm_en, variant, sense, open_s, tied_s,
		temp_s} = sync_q;

	// Third channel only supplies the duty-input off timeout
	assign chan_en = {pwm_en, sub_en, main_en};
	for (genvar g = 0; g < 3; g++) begin : g_chan
		dim_channel #(
			.PULSE_MAX  (PULSE_MAX),
			.OFF_TIMEOUT(OFF_TIMEOUT)
		) u_chan (
			.core_clk  (core_clk),
			.reset_n   (reset_n),
			.enable_dim(chan_en[g]),
			.ramp_go   (pump_ready),
			.stat      (stat[g])
		);
	end

	assign grp_active = variant ? {2{stat[2].active}}
		: {stat[1].active, stat[0].active};
	assign grp_drive[0] = stat[0].drive;
	assign grp_drive[1] = stat[1].drive;
	assign any_active = grp_active[0] | grp_active[1];
	assign run = any_active & ~thermal_sd_q;
	assign pump_ready = (cp_q == CP_ONE_X) || (cp_q == CP_ONE_HALF_X);
	assign ramp_any = ~variant & (stat[0].ramping | stat[1].ramping);
	assign ramp_end = variant | (ramp_prev_q & ~ramp_any);
	assign ovp_gate = (|(open_s & ~tied_s)) & sense.out_above_5v;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			ramp_prev_q <= 1'b0;
		else
			ramp_prev_q <= ramp_any;
	end

	// Hysteresis keeps the part off until it cools
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			thermal_sd_q <= 1'b0;
		else if (temp_s >= TSD_TRIP_C)
			thermal_sd_q <= 1'b1;
		else if (temp_s <= TSD_TRIP_C - TSD_HYST_C)
			thermal_sd_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cp_q <= CP_OFF;
		end else if (!run) begin
			cp_q <= CP_OFF;
		end else begin
			case (cp_q)
				CP_OFF: cp_q <= CP_PRECHARGE;
				CP_PRECHARGE:
					if (sense.out_near_in && !sense.out_short)
						cp_q <= CP_ONE_X;
				CP_ONE_X:
					if (sense.out_short)
						cp_q <= CP_PRECHARGE;
					else if (sense.min_cathode_voltage_low)
						cp_q <= CP_ONE_HALF_X;
					else if (ramp_end && sense.reg_dropout)
						cp_q <= CP_ONE_HALF_X;
				CP_ONE_HALF_X:
					if (sense.out_short)
						cp_q <= CP_PRECHARGE;
					else if (sense.headroom_ok
						&& !sense.min_cathode_voltage_low)
						cp_q <= CP_ONE_X;
				default: cp_q <= CP_OFF;
			endcase
		end
	end

	// Pump clock held low outside 1.5x and while an open, untied LED sees the output above 5V
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_q <= '0;
			cp_clk_q <= 1'b0;
		end else if (cp_q != CP_ONE_HALF_X || ovp_gate) begin
			half_q <= '0;
			cp_clk_q <= 1'b0;
		end else if (half_q == 7'(CP_HALF_CYC - 1)) begin
			half_q <= '0;
			cp_clk_q <= ~cp_clk_q;
		end else begin
			half_q <= half_q + 7'h01;
		end
	end

	// Slow first-order filter; corner far below the lowest duty rate
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			acc_q <= '0;
		else
			acc_q <= acc_q - (acc_q >> FILT_SHIFT)
				+ (pwm_en ? (FILT_SHIFT+6)'(32) : '0);
	end
	assign duty_level = acc_q[FILT_SHIFT+5:FILT_SHIFT];

	always_comb begin
		derate_mv = 12'(temp_s - DERATE_KNEE_C) * DERATE_MV_PER_C;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			ref_mv <= REF_NOM_MV;
		else if (temp_s <= DERATE_KNEE_C)
			ref_mv <= REF_NOM_MV;
		else if (derate_mv >= 12'(REF_NOM_MV))
			ref_mv <= '0;
		else
			ref_mv <= REF_NOM_MV - derate_mv[9:0];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_enable <= '0;
			led_current <= '0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				reg_enable[i] <= run & ~tied_s[i]
					& grp_active[group_of(i)];
				if (!run || !pump_ready || tied_s[i]
					|| !grp_active[group_of(i)])
					led_current[i] <= '0;
				else if (variant)
					led_current[i] <= duty_level;
				else
					led_current[i] <= grp_drive[group_of(i)];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shutdown <= 1'b1;
			cathode_target_mv <= CATHODE_LOW_MV;
		end else begin
			shutdown <= ~any_active;
			cathode_target_mv <= (cp_q == CP_ONE_HALF_X)
				? CATHODE_REG_MV : CATHODE_LOW_MV;
		end
	end

	assign cp_mode = cp_q;
	assign cp_switch_clk = cp_clk_q;
	assign ramp_src_en = (cp_q == CP_PRECHARGE);
	assign out_pulldown_en = shutdown;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_pre_done;
		cp_q == CP_PRECHARGE && run && sense.out_near_in
			&& !sense.out_short;
	endsequence

	chk_precharge_exit: assert property (
		s_pre_done |=> cp_q == CP_ONE_X ##0 !ramp_src_en)
		else $error("precharge did not hand over to 1x");
	chk_short_hold: assert property (
		cp_q == CP_PRECHARGE && run && sense.out_short
		|=> cp_q == CP_PRECHARGE && ramp_src_en)
		else $error("shorted output left precharge");
	chk_dropout_boost: assert property (
		cp_q == CP_ONE_X && run && !sense.out_short && ramp_end
			&& sense.reg_dropout |=> cp_q == CP_ONE_HALF_X)
		else $error("dropout after ramp kept 1x");
	chk_cathode_boost: assert property (
		cp_q == CP_ONE_X && run && !sense.out_short
			&& sense.min_cathode_voltage_low
		|=> cp_q == CP_ONE_HALF_X ##1 cathode_target_mv == CATHODE_REG_MV)
		else $error("low cathode did not select 1.5x");
	chk_headroom_back: assert property (
		cp_q == CP_ONE_HALF_X && run && !sense.headroom_ok
		|=> cp_q != CP_ONE_X)
		else $error("left 1.5x without headroom");
	chk_pump_idle: assert property (
		cp_q != CP_ONE_HALF_X || ovp_gate |=> !cp_switch_clk)
		else $error("pump clock ran outside 1.5x");
	chk_pump_half: assert property (
		$rose(cp_switch_clk) |=> ($stable(cp_switch_clk)
			|| $past(cp_q) != CP_ONE_HALF_X || $past(ovp_gate))[*8])
		else $error("pump clock half period too short");
	chk_thermal_off: assert property (
		$rose(thermal_sd_q) |=> cp_q == CP_OFF ##1 reg_enable == 5'h00)
		else $error("thermal trip did not stop the pump");
	chk_shutdown_both: assert property (
		!any_active |=> shutdown && out_pulldown_en)
		else $error("idle enables did not shut down");
	chk_tied_disable: assert property (
		1'b1 |=> (reg_enable & $past(tied_s)) == 5'h00)
		else $error("tied LED kept its regulator on");
	chk_derate_ref: assert property (
		temp_s <= DERATE_KNEE_C |=> ref_mv == REF_NOM_MV)
		else $error("reference derated below the knee");
endmodule // led_pulse_dim_sequencer

// File: tb/host_pulse_model.sv
/*
 Host model: drives both enable pins and the duty pin.
 Assumes the caller waits for its tasks; pins move 1 ns after an edge.
*/
`timescale 1ns/10ps
module host_pulse_model (
	// Clock
	input  wire logic core_clk,
	// Host pins
	output logic      main_group_enable_dim,
	output logic      sub_group_enable_dim,
	output logic      pwm_dim_in
);
	initial begin
		main_group_enable_dim = 1'b0;
		sub_group_enable_dim  = 1'b0;
		pwm_dim_in            = 1'b0;
	end

	// Pin 0 main, 1 sub, 2 duty input
	task automatic drive(input int pin, input logic v);
		@(posedge core_clk);
		#1;
		case (pin)
			0: main_group_enable_dim = v;
			1: sub_group_enable_dim = v;
			default: pwm_dim_in = v;
		endcase
	endtask

	// Low for low_cyc cycles, then 20 high; short widths are misuse
	task automatic pulse(input int pin, input int low_cyc);
		drive(pin, 1'b0);
		repeat (low_cyc - 1) @(posedge core_clk);
		drive(pin, 1'b1);
		repeat (20) @(posedge core_clk);
	endtask
endmodule // host_pulse_model

// File: tb/led_pulse_dim_sequencer_tb.sv
/*
 Self-checking bench for the backlight sequencer.
 Assumes shortened counts: pulse max 400, timeout 2000, filter shift 4.
*/
`timescale 1ns/10ps
module led_pulse_dim_sequencer_tb;
	import led_seq_pkg::*;
	logic             core_clk;
	logic             reset_n;
	logic             main_en;
	logic             sub_en;
	logic             pwm;
	logic             duty_variant_sel;
	sense_t           sense_in;
	logic [4:0]       led_open;
	logic [4:0]       led_tied_out;
	logic [7:0]       die_temp_c;
	cp_mode_t         cp_mode;
	logic             cp_switch_clk;
	logic             ramp_src_en;
	logic             shutdown;
	logic             out_pulldown_en;
	logic [7:0]       cathode_target_mv;
	logic [9:0]       ref_mv;
	logic [4:0]       reg_enable;
	logic [4:0][5:0]  led_current;
	int               n_errors;
	int               comparisons;

	host_pulse_model u_host (
		.core_clk              (core_clk),
		.main_group_enable_dim (main_en),
		.sub_group_enable_dim  (sub_en),
		.pwm_dim_in            (pwm)
	);

	led_pulse_dim_sequencer #(
		.PULSE_MAX   (20'd400),
		.OFF_TIMEOUT (20'd2000),
		.FILT_SHIFT  (4)
	) u_dut (
		.core_clk              (core_clk),
		.reset_n               (reset_n),
		.main_group_enable_dim (main_en),
		.sub_group_enable_dim  (sub_en),
		.pwm_dim_in            (pwm),
		.duty_variant_sel      (duty_variant_sel),
		.sense_in              (sense_in),
		.led_open              (led_open),
		.led_tied_out          (led_tied_out),
		.die_temp_c            (die_temp_c),
		.cp_mode               (cp_mode),
		.cp_switch_clk         (cp_switch_clk),
		.ramp_src_en           (ramp_src_en),
		.shutdown              (shutdown),
		.out_pulldown_en       (out_pulldown_en),
		.cathode_target_mv     (cathode_target_mv),
		.ref_mv                (ref_mv),
		.reg_enable            (reg_enable),
		.led_current           (led_current)
	);

	always #2 core_clk = ~core_clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input string w, input logic [31:0] s,
			input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", w, e, s);
		end
	endtask

	// Bounded wait for one LED's current to reach v
	task automatic wcur(input int i, input logic [5:0] v, input int lim);
		int k;
		k = 0;
		while (led_current[i] !== v && k < lim) begin
			cyc(1);
			k++;
		end
		chk("led current", 32'(led_current[i]), 32'(v));
	endtask

	task automatic complete_run();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_soft_start();
		u_host.drive(0, 1'b1);
		cyc(10);
		chk("precharge", 32'(cp_mode), 32'(CP_PRECHARGE));
		chk("ramp source", 32'(ramp_src_en), 32'h1);
		sense_in.out_short   = 1'b1;
		sense_in.out_near_in = 1'b1;
		cyc(20);
		chk("short holds", 32'(cp_mode), 32'(CP_PRECHARGE));
		sense_in.out_short = 1'b0;
		cyc(10);
		chk("enter 1x", 32'(cp_mode), 32'(CP_ONE_X));
		cyc(1000);
		chk("ramping", 32'(led_current[0] < 6'h20), 32'h1);
		wcur(0, LEVEL_FULL, 9000);
		chk("main 2", 32'(led_current[2]), 32'h20);
		chk("sub idle", 32'(led_current[3]), 32'h0);
	endtask

	task automatic t_early_dim();
		u_host.drive(1, 1'b1);
		cyc(20);
		for (int i = 0; i < 3; i++)
			u_host.pulse(1, 200);
		wcur(3, 6'h1D, 9000);
		chk("sub 4", 32'(led_current[4]), 32'h1D);
		chk("main kept", 32'(led_current[0]), 32'h20);
	endtask

	task automatic t_dim_wrap();
		u_host.pulse(0, 50);
		cyc(10);
		chk("short ignored", 32'(led_current[0]), 32'h20);
		u_host.pulse(0, 600);
		cyc(10);
		chk("gap ignored", 32'(led_current[0]), 32'h20);
		u_host.pulse(0, 200);
		chk("one step", 32'(led_current[0]), 32'h1F);
		for (int i = 0; i < 30; i++)
			u_host.pulse(0, 200);
		chk("lowest", 32'(led_current[0]), 32'h01);
		chk("sub kept", 32'(led_current[3]), 32'h1D);
		sense_in.reg_dropout = 1'b1;
		u_host.pulse(0, 200);
		chk("wrap ramps", 32'(led_current[0] < 6'h20), 32'h1);
		chk("no early 1.5x", 32'(cp_mode), 32'(CP_ONE_X));
		wcur(0, LEVEL_FULL, 9000);
		cyc(5);
		chk("dropout 1.5x", 32'(cp_mode), 32'(CP_ONE_HALF_X));
		sense_in.reg_dropout = 1'b0;
		sense_in.headroom_ok = 1'b1;
		cyc(10);
		chk("back 1x", 32'(cp_mode), 32'(CP_ONE_X));
	endtask

	task automatic t_pump();
		int       k;
		logic     p;
		sense_in.headroom_ok             = 1'b0;
		sense_in.min_cathode_voltage_low = 1'b1;
		cyc(10);
		chk("low cathode", 32'(cp_mode), 32'(CP_ONE_HALF_X));
		chk("target", 32'(cathode_target_mv), 32'(CATHODE_REG_MV));
		for (int n = 0; n < 2; n++) begin
			k = 0;
			p = cp_switch_clk;
			while (cp_switch_clk === p && k < 300) begin
				cyc(1);
				k++;
			end
		end
		chk("half period", 32'(k), 32'(CP_HALF_CYC));
		sense_in.min_cathode_voltage_low = 1'b0;
		cyc(10);
		chk("no headroom", 32'(cp_mode), 32'(CP_ONE_HALF_X));
		led_open[1]           = 1'b1;
		sense_in.out_above_5v = 1'b1;
		cyc(5);
		k = 0;
		for (int i = 0; i < 300; i++) begin
			k += int'(cp_switch_clk !== 1'b0);
			cyc(1);
		end
		chk("pump gated", 32'(k), 32'h0);
		led_open              = 5'h00;
		sense_in.out_above_5v = 1'b0;
		sense_in.headroom_ok  = 1'b1;
		cyc(10);
		chk("headroom 1x", 32'(cp_mode), 32'(CP_ONE_X));
		chk("target 1x", 32'(cathode_target_mv), 32'(CATHODE_LOW_MV));
		sense_in.out_short = 1'b1;
		cyc(5);
		chk("short 1x", 32'(cp_mode), 32'(CP_PRECHARGE));
		sense_in.out_short = 1'b0;
		cyc(5);
		chk("short gone", 32'(cp_mode), 32'(CP_ONE_X));
		led_tied_out[4] = 1'b1;
		cyc(5);
		chk("tied off", 32'(reg_enable[4:3]), 32'h1);
		chk("tied cur", 32'(led_current[4]), 32'h0);
		led_tied_out = 5'h00;
	endtask

	task automatic t_thermal();
		die_temp_c = 8'h46;
		cyc(5);
		chk("derate", 32'(ref_mv), 32'h12C);
		die_temp_c = 8'hA0;
		cyc(5);
		chk("hot off", 32'(cp_mode), 32'(CP_OFF));
		chk("hot cur", 32'(led_current[0]), 32'h0);
		die_temp_c = 8'h96;
		cyc(5);
		chk("hysteresis", 32'(cp_mode), 32'(CP_OFF));
		die_temp_c = 8'h8C;
		wcur(0, LEVEL_FULL, 9000);
		die_temp_c = 8'h19;
		cyc(5);
		chk("nominal ref", 32'(ref_mv), 32'(REF_NOM_MV));
	endtask

	task automatic t_off();
		u_host.drive(1, 1'b0);
		cyc(2100);
		chk("sub off", 32'(led_current[4:3]), 32'h0);
		chk("main on", 32'(led_current[0]), 32'h20);
		chk("not down", 32'(shutdown), 32'h0);
		u_host.drive(0, 1'b0);
		cyc(2100);
		chk("shutdown", 32'(shutdown), 32'h1);
		chk("pulldown", 32'(out_pulldown_en), 32'h1);
		chk("pump off", 32'(cp_mode), 32'(CP_OFF));
	endtask

	task automatic t_duty();
		duty_variant_sel = 1'b1;
		u_host.drive(2, 1'b1);
		wcur(0, LEVEL_FULL, 10000);
		for (int i = 1; i < 5; i++)
			chk("duty led", 32'(led_current[i]), 32'h20);
		u_host.drive(2, 1'b0);
		cyc(2100);
		chk("duty down", 32'(shutdown), 32'h1);
	endtask

	initial begin
		core_clk         = 1'b0;
		reset_n          = 1'b0;
		n_errors         = 0;
		comparisons      = 0;
		duty_variant_sel = 1'b0;
		sense_in         = '0;
		led_open         = 5'h00;
		led_tied_out     = 5'h00;
		die_temp_c       = 8'h19;
		cyc(5);
		chk("reset down", 32'(shutdown), 32'h1);
		chk("reset pump", 32'(cp_mode), 32'(CP_OFF));
		reset_n = 1'b1;
		cyc(2);
		chk("reset ref", 32'(ref_mv), 32'(REF_NOM_MV));
		chk("reset regs", 32'(reg_enable), 32'h0);
		t_soft_start();
		t_early_dim();
		t_dim_wrap();
		t_pump();
		t_thermal();
		t_off();
		t_duty();
		complete_run();
	end

	// Whole run is near 40k cycles
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		complete_run();
	end
endmodule // led_pulse_dim_sequencer_tb
